// [hw/trm_trigger_matrix.sv]
// Functional notes
// RULE1 - lvds direction bit: 0 input or unused, 1 carrier drives the line
// RULE2 - lvds edge/level bit honoured only for input lines; 0 edge, 1 level
// RULE3 - edge pick bit: 0 rising, 1 falling strobe edge; ignored in level mode
// RULE4 - source type: 000 ttl in, 001 lvds, 010 module A, 011 module B, rest reserved
// RULE5 - index field picks source instance for outputs, strobe number for inputs
// RULE6 - index ignored when source type is the ttl input
// RULE7 - software must set any named source or strobe source as an input
// RULE8 - polarity bit: 0 pass, 1 invert, on every path; the ttl input invert bit 11 is masked off, so that path never inverts
// RULE9 - enable bit must be 1 for a path or strobe to take part
// RULE10 - threshold output follows ttl threshold bit: 0 is 2.5V, 1 is 1.4V
// RULE11 - termination output follows ttl impedance bit: 0 high-z, 1 is 50 ohm
// RULE12 - ttl input edge/level bit always applies: 0 edge, 1 level
// RULE13 - ttl input strobe number used only in edge mode
// RULE14 - ttl output: enable 15, invert 11, type and index, driven from input
// RULE15 - strobe 1 upper byte, strobe 0 lower byte of one register
// RULE16 - strobe 3 upper byte, strobe 2 lower byte of a second register
// RULE17 - level mode passes through, edge mode latches on selected strobe edge
// RULE18 - one conditioned input may drive any number of outputs
// RULE19 - eight lvds lines numbered 0 to 7, each separately configured
// RULE20 - unused and reserved bits ignore writes and read zero
// RULE21 - asynchronous trigger inputs are synchronised before edge detection
//
// The implementer's own choice: register access over APB.
`timescale 1ns/1ns
`default_nettype none
module trm_trigger_matrix
  import trm_pkg::*;
(
  input wire logic clk,
  input wire logic rst_b,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic ttlIn,
  output logic ttlOut,
  output logic thresholdSel,
  output logic terminationSel,
  input wire logic [NUM_LVDS-1:0] lvdsIn,
  output logic [NUM_LVDS-1:0] lvdsOut,
  output logic [NUM_LVDS-1:0] lvdsOe,
  input wire logic [NUM_MOD-1:0] modTrigA,
  input wire logic [NUM_MOD-1:0] modTrigB
);

  // ==========================================================
  // source selection shared by strobes and outputs
  // the ttl type ignores the index, so one selector serves all
  function automatic logic pick_src(
    input logic [2:0] typ,
    input logic [2:0] idx,
    input logic ttl,
    input logic [NUM_LVDS-1:0] lvds,
    input logic [NUM_MOD-1:0] modA,
    input logic [NUM_MOD-1:0] modB
  );
    logic res;
    res = 1'b0;
    case (typ)
      SRC_TTL: res = ttl; // RULE6
      SRC_LVDS: res = lvds[idx];
      SRC_MOD_A: res = modA[idx];
      SRC_MOD_B: res = modB[idx];
      default: res = 1'b0; // RULE4
    endcase
    return res;
  endfunction

  // ==========================================================
  // control registers
  logic [15:0] ttlInCtl;
  logic [15:0] ttlOutCtl;
  logic [15:0] strobeLo;
  logic [15:0] strobeHi;
  // one control word per line, picked by the low index bits
  logic [15:0] lvdsCtl [0:NUM_LVDS-1];

  // ==========================================================
  // ttl control fields, named once for the paths below
  wire ttlInOn = ttlInCtl[BIT_ENABLE];
  wire ttlInLevel = ttlInCtl[BIT_LATCH_MODE];
  wire ttlInFall = ttlInCtl[BIT_EDGE_PICK];
  wire ttlInFlip = ttlInCtl[BIT_INVERT];
  wire [1:0] ttlInStrobe = ttlInCtl[INDEX_LSB +: 2];
  wire ttlOutOn = ttlOutCtl[BIT_ENABLE];
  wire ttlOutFlip = ttlOutCtl[BIT_INVERT];
  wire [2:0] ttlOutType = ttlOutCtl[TYPE_LSB +: 3];
  wire [2:0] ttlOutIndex = ttlOutCtl[INDEX_LSB +: 3];

  // ==========================================================
  // apb decode
  // pure decode; pready answers one cycle after setup
  wire [9:0] regIdx = paddr[11:2];
  wire aligned = (paddr[1:0] == 2'h0);
  wire [9:0] lvdsOff = regIdx - IDX_LVDS_BASE;
  wire hitTtlIn = aligned && (regIdx == IDX_TTL_IN);
  wire hitTtlOut = aligned && (regIdx == IDX_TTL_OUT);
  wire hitStrobeLo = aligned && (regIdx == IDX_STROBE_LO);
  wire hitStrobeHi = aligned && (regIdx == IDX_STROBE_HI);
  wire hitLvds = aligned && (regIdx >= IDX_LVDS_BASE) && (lvdsOff < 10'(NUM_LVDS));
  wire mapped = hitTtlIn | hitTtlOut | hitStrobeLo | hitStrobeHi | hitLvds;
  wire setupPhase = psel & ~penable;
  wire accessDone = psel & penable & pready;
  wire doWrite = accessDone & pwrite & mapped;
  wire [15:0] wrData = pwdata[15:0];
  wire [2:0] lvdsSel = lvdsOff[2:0];
  // read mux, unmapped words read zero
  wire [15:0] readWord = hitTtlIn ? ttlInCtl :
                         hitTtlOut ? ttlOutCtl :
                         hitStrobeLo ? strobeLo :
                         hitStrobeHi ? strobeHi :
                         hitLvds ? lvdsCtl[lvdsSel] : 16'h0000;

  // answer one cycle after setup, data and error captured at setup
  // zero outside the answer keeps stale data off the bus
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h00000000;
    end else begin
      pready <= setupPhase;
      pslverr <= setupPhase & ~mapped;
      prdata <= setupPhase ? {16'h0000, readWord} : 32'h00000000; // RULE20
    end
  end

  // register writes, reserved bits masked off
  // writes land only at the access edge, with pready high
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      ttlInCtl <= RST_CTL;
      ttlOutCtl <= RST_CTL;
      strobeLo <= RST_CTL;
      strobeHi <= RST_CTL;
    end else if (doWrite) begin
      if (hitTtlIn) ttlInCtl <= wrData & MASK_TTL_IN; // RULE20
      if (hitTtlOut) ttlOutCtl <= wrData & MASK_TTL_OUT; // RULE14
      if (hitStrobeLo) strobeLo <= wrData & MASK_STROBE; // RULE15
      if (hitStrobeHi) strobeHi <= wrData & MASK_STROBE; // RULE16
    end
  end

  // per-line registers, one word for each lvds line
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      for (int i = 0; i < NUM_LVDS; i++) begin
        lvdsCtl[i] <= RST_CTL;
      end
    end else if (doWrite && hitLvds) begin
      lvdsCtl[lvdsSel] <= wrData & MASK_LVDS; // RULE19
    end
  end

  // ==========================================================
  // input synchronisers
  logic ttlMeta;
  logic ttlSync;
  logic [NUM_LVDS-1:0] lvdsMeta;
  logic [NUM_LVDS-1:0] lvdsSync;
  logic [NUM_MOD-1:0] modAMeta;
  logic [NUM_MOD-1:0] modASync;
  logic [NUM_MOD-1:0] modBMeta;
  logic [NUM_MOD-1:0] modBSync;

  // limitation: pulses shorter than one clock may be missed
  // two flops on every pin; only the second stage feeds logic
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      ttlMeta <= 1'b0;
      ttlSync <= 1'b0;
      lvdsMeta <= '0;
      lvdsSync <= '0;
      modAMeta <= '0;
      modASync <= '0;
      modBMeta <= '0;
      modBSync <= '0;
    end else begin
      ttlMeta <= ttlIn;
      ttlSync <= ttlMeta; // RULE21
      lvdsMeta <= lvdsIn;
      lvdsSync <= lvdsMeta;
      modAMeta <= modTrigA;
      modASync <= modAMeta;
      modBMeta <= modTrigB;
      modBSync <= modBMeta;
    end
  end

  // ==========================================================
  // edge strobes, taken from synchronised raw inputs to avoid feedback
  // a strobe built from a conditioned path would loop through its own latch
  wire [31:0] strobeCfgAll = {strobeHi, strobeLo};
  logic [NUM_STROBE-1:0] strobe;
  logic [NUM_STROBE-1:0] strobePrev;
  wire [NUM_STROBE-1:0] strobeRise = strobe & ~strobePrev;
  wire [NUM_STROBE-1:0] strobeFall = ~strobe & strobePrev;

  genvar k;
  generate
    for (k = 0; k < NUM_STROBE; k++) begin : g_strobe
      wire [7:0] cfg = strobeCfgAll[8*k +: 8]; // RULE15 RULE16
      assign strobe[k] = cfg[STROBE_EN_BIT] &
        pick_src(cfg[TYPE_LSB +: 3], cfg[INDEX_LSB +: 3], ttlSync, lvdsSync, modASync, modBSync); // RULE9
    end
  endgenerate

  // previous strobe level for edge detection
  // enabling a strobe whose source sits high counts as a rise
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      strobePrev <= '0;
    end else begin
      strobePrev <= strobe; // RULE21
    end
  end

  // ==========================================================
  // input conditioning
  logic ttlCond;
  logic [NUM_LVDS-1:0] lvdsCond;

  // ttl input: latch mode always applies, strobe number only in edge mode
  trm_conditioner u_ttl_cond (
    .clk(clk),
    .rst_b(rst_b),
    .sig(ttlSync),
    .active(ttlInOn),
    .levelMode(ttlInLevel), // RULE12
    .fallPick(ttlInFall),
    .strobeIdx(ttlInStrobe), // RULE13
    .invert(ttlInFlip),
    .strobeRise(strobeRise),
    .strobeFall(strobeFall),
    .condOut(ttlCond)
  );

  // lvds lines: the edge/level bit matters only while the line is an input
  genvar i;
  generate
    for (i = 0; i < NUM_LVDS; i++) begin : g_lvds_in
      wire [15:0] c = lvdsCtl[i];
      wire lineIn = ~c[BIT_DIRECTION];
      wire lineOn = c[BIT_ENABLE] & lineIn;
      // an output line never feeds the routing as a conditioned input; strobes still see its level
      trm_conditioner u_cond (
        .clk(clk),
        .rst_b(rst_b),
        .sig(lvdsSync[i]),
        .active(lineOn), // RULE2 RULE9
        .levelMode(c[BIT_LATCH_MODE]),
        .fallPick(c[BIT_EDGE_PICK]),
        .strobeIdx(c[1:0]), // RULE5
        .invert(c[BIT_INVERT]),
        .strobeRise(strobeRise),
        .strobeFall(strobeFall),
        .condOut(lvdsCond[i])
      );
    end
  endgenerate

  // ==========================================================
  // output routing; a conditioned input fans out to every output naming it
  // a line pointed at itself sees its own gated-off input, a constant zero
  logic [NUM_LVDS-1:0] next_lvdsOut;
  logic [NUM_LVDS-1:0] next_lvdsOe;

  generate
    for (i = 0; i < NUM_LVDS; i++) begin : g_lvds_out
      wire [15:0] c = lvdsCtl[i];
      wire lineOutOn = c[BIT_DIRECTION] & c[BIT_ENABLE];
      wire srcBit = pick_src(c[TYPE_LSB +: 3], c[INDEX_LSB +: 3], ttlCond, lvdsCond, modASync, modBSync); // RULE18
      assign next_lvdsOe[i] = c[BIT_DIRECTION]; // RULE1
      assign next_lvdsOut[i] = lineOutOn & (srcBit ^ c[BIT_INVERT]); // RULE8
    end
  endgenerate

  wire ttlSrc = pick_src(ttlOutType, ttlOutIndex,
                         ttlCond, lvdsCond, modASync, modBSync); // RULE14
  wire next_ttlOut = ttlOutOn & (ttlSrc ^ ttlOutFlip);

  // registered pins, so every output comes straight from a flop
  // threshold and termination are plain copies of the ttl input bits
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      lvdsOut <= '0;
      lvdsOe <= '0;
      ttlOut <= 1'b0;
      thresholdSel <= 1'b0;
      terminationSel <= 1'b0;
    end else begin
      lvdsOut <= next_lvdsOut;
      lvdsOe <= next_lvdsOe; // RULE1
      ttlOut <= next_ttlOut; // RULE9
      thresholdSel <= ttlInCtl[BIT_THRESH]; // RULE10
      terminationSel <= ttlInCtl[BIT_TERM]; // RULE11
    end
  end

endmodule
`default_nettype wire

// [hw/trm_pkg.sv]
package trm_pkg;

  // ==========================================================
  // sizes
  localparam int NUM_LVDS = 8;
  localparam int NUM_MOD = 8;
  localparam int NUM_STROBE = 4;
  localparam int SYNC_STAGES = 2;

  // ==========================================================
  // register indices (byte address is four times the index)
  localparam logic [9:0] IDX_TTL_IN = 10'h050;
  localparam logic [9:0] IDX_TTL_OUT = 10'h052;
  localparam logic [9:0] IDX_STROBE_LO = 10'h058;
  localparam logic [9:0] IDX_STROBE_HI = 10'h05a;
  localparam logic [9:0] IDX_LVDS_BASE = 10'h060; // lines 0..7 at 0x60..0x67

  // ==========================================================
  // writable bit masks, everything else reads zero
  localparam logic [15:0] MASK_TTL_IN = 16'he603;
  localparam logic [15:0] MASK_TTL_OUT = 16'h8877;
  localparam logic [15:0] MASK_STROBE = 16'hf7f7;
  localparam logic [15:0] MASK_LVDS = 16'h8f77;

  // ==========================================================
  // reset values
  localparam logic [15:0] RST_CTL = 16'h0000;

  // ==========================================================
  // common field positions for trigger paths
  localparam int BIT_ENABLE = 15;
  localparam int BIT_THRESH = 14;
  localparam int BIT_TERM = 13;
  localparam int BIT_INVERT = 11;
  localparam int BIT_EDGE_PICK = 10;
  localparam int BIT_LATCH_MODE = 9;
  localparam int BIT_DIRECTION = 8;
  localparam int TYPE_LSB = 4;
  localparam int INDEX_LSB = 0;
  // strobe byte: enable 7, type 6:4, index 2:0
  localparam int STROBE_EN_BIT = 7;

  // ==========================================================
  // source type codes
  localparam logic [2:0] SRC_TTL = 3'h0;
  localparam logic [2:0] SRC_LVDS = 3'h1;
  localparam logic [2:0] SRC_MOD_A = 3'h2;
  localparam logic [2:0] SRC_MOD_B = 3'h3;

endpackage

// [hw/trm_conditioner.sv]
`timescale 1ns/1ns
`default_nettype none
module trm_conditioner
  import trm_pkg::*;
(
  input wire logic clk,
  input wire logic rst_b,
  input wire logic sig,
  input wire logic active,
  input wire logic levelMode,
  input wire logic fallPick,
  input wire logic [1:0] strobeIdx,
  input wire logic invert,
  input wire logic [NUM_STROBE-1:0] strobeRise,
  input wire logic [NUM_STROBE-1:0] strobeFall,
  output logic condOut
);

  // ==========================================================
  // edge capture
  logic latched;
  wire capture = fallPick ? strobeFall[strobeIdx] : strobeRise[strobeIdx]; // RULE3
  wire shaped = (levelMode ? sig : latched) ^ invert; // RULE17 RULE8

  // latch the trigger only on the chosen strobe edge
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      latched <= 1'b0;
    end else if (capture) begin
      latched <= sig; // RULE17
    end
  end

  // disabled or non-input paths stay low
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      condOut <= 1'b0;
    end else begin
      condOut <= active & shaped; // RULE9
    end
  end

endmodule
`default_nettype wire

// [test/trm_trigger_monitor.sv]
`timescale 1ns/1ns
`default_nettype none
module trm_trigger_monitor
  import trm_pkg::*;
(
  input wire logic clk,
  input wire logic rst_b,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic thresholdSel,
  input wire logic terminationSel,
  input wire logic [NUM_LVDS-1:0] lvdsOut,
  input wire logic [NUM_LVDS-1:0] lvdsOe
);
  // ====
  // completed writes of interest
  wire logic acc = psel && penable && pready && pwrite;
  wire logic wrTtl = acc && paddr == 12'h140;
  wire logic wrLine0 = acc && paddr == 12'h180;

  // ====
  // properties, one clock and one reset
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);
  a_ready_next: assert property (psel && !penable |=> pready) else $error("no answer after setup");
  a_ready_once: assert property (pready |=> !pready) else $error("answer held too long");
  a_err_misaligned: assert property (pready && paddr[1:0] != 2'h0 |-> pslverr && prdata == 32'h0)
    else $error("misaligned access not refused");
  a_err_mapped: assert property (pready && paddr == 12'h148 |-> !pslverr) else $error("mapped access refused");
  a_upper_zero: assert property (pready |-> prdata[31:16] == 16'h0) else $error("upper read bits set");
  a_idle_zero: assert property (!pready |-> prdata == 32'h0) else $error("read data outside answer");
  a_dir_oe: assert property (wrLine0 |-> ##2 lvdsOe[0] == $past(pwdata[8], 2))
    else $error("enable does not follow direction");
  a_thresh_follow: assert property (wrTtl |-> ##2 thresholdSel == $past(pwdata[14], 2))
    else $error("threshold select wrong");
  a_term_follow: assert property (wrTtl |-> ##2 terminationSel == $past(pwdata[13], 2))
    else $error("termination select wrong");
  // drive value and enable leave the same register stage, so no slack
  a_drive_quiet: assert property ((~lvdsOe & lvdsOut) == 8'h0)
    else $error("undriven line carries data");
endmodule

bind trm_trigger_matrix trm_trigger_monitor i_mon (.clk, .rst_b, .psel, .penable, .pwrite, .paddr, .pwdata,
  .prdata, .pready, .pslverr, .thresholdSel, .terminationSel, .lvdsOut, .lvdsOe);
`default_nettype wire

// [test/trm_far_side.sv]
`timescale 1ns/1ns
`default_nettype none
module trm_far_side
  import trm_pkg::*;
(
  input wire logic ttlDrv,
  input wire logic [NUM_LVDS-1:0] lvdsDrv,
  input wire logic [NUM_MOD-1:0] modADrv,
  input wire logic [NUM_MOD-1:0] modBDrv,
  input wire logic [NUM_LVDS-1:0] lvdsOut,
  input wire logic [NUM_LVDS-1:0] lvdsOe,
  output logic ttlIn,
  output logic [NUM_LVDS-1:0] lvdsIn,
  output logic [NUM_MOD-1:0] modTrigA,
  output logic [NUM_MOD-1:0] modTrigB
);
  // ====
  // a line the carrier drives shows its level, else the far end's
  assign lvdsIn = (lvdsOe & lvdsOut) | (~lvdsOe & lvdsDrv);
  // connector and modules always drive their own lines
  assign ttlIn = ttlDrv;
  assign modTrigA = modADrv;
  assign modTrigB = modBDrv;
endmodule
`default_nettype wire

// [test/trm_trigger_matrix_bench.sv]
`timescale 1ns/1ns
`default_nettype none
module trm_trigger_matrix_bench
  import trm_pkg::*;
;
  // ====
  // stimulus and observed signals
  logic clk = 1'b0;
  logic rst_b = 1'b0;
  logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0, ttlDrv = 1'b0;
  logic [11:0] paddr = 12'h0;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready, pslverr, ttlIn, ttlOut, thresholdSel, terminationSel;
  logic [7:0] lvdsIn, lvdsOut, lvdsOe, modTrigA, modTrigB;
  logic [7:0] lvdsDrv = 8'h0, modADrv = 8'h0, modBDrv = 8'h0;
  int mismatches = 0, comparisons = 0;

  always #20 clk = ~clk;

  trm_trigger_matrix i_dut (.clk(clk), .rst_b(rst_b), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .ttlIn(ttlIn),
    .ttlOut(ttlOut), .thresholdSel(thresholdSel), .terminationSel(terminationSel), .lvdsIn(lvdsIn),
    .lvdsOut(lvdsOut), .lvdsOe(lvdsOe), .modTrigA(modTrigA), .modTrigB(modTrigB));
  trm_far_side i_far (.ttlDrv(ttlDrv), .lvdsDrv(lvdsDrv), .modADrv(modADrv), .modBDrv(modBDrv),
    .lvdsOut(lvdsOut), .lvdsOe(lvdsOe), .ttlIn(ttlIn), .lvdsIn(lvdsIn), .modTrigA(modTrigA),
    .modTrigB(modTrigB));

  // ====
  // shared tasks
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] want);
    comparisons++;
    if (seen !== want) begin
      mismatches++;
      $display("[FAIL] %s expected %h seen %h", what, want, seen);
    end
  endtask

  // setup one edge after entry, so a release is never overwritten in the same step
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d, output logic [31:0] q,
                     output logic e);
    int n;
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (pready !== 1'b1) begin
      mismatches++;
      $display("[FAIL] apb answer expected 1 seen %b", pready);
    end
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [11:0] a, input logic [15:0] d);
    logic [31:0] q;
    logic e;
    apb(1'b1, a, {16'h0, d}, q, e);
  endtask

  task automatic rd(input logic [11:0] a, input logic [15:0] want, input logic err);
    logic [31:0] q;
    logic e;
    apb(1'b0, a, 32'h0, q, e);
    check("read data", q, {16'h0, want});
    check("slave error", e, err);
  endtask

  // outputs settle within eight edges on level and edge paths alike
  task automatic pins(input logic t, input logic [7:0] l, input logic [7:0] a, input logic [7:0] b);
    @(posedge clk);
    ttlDrv <= t;
    lvdsDrv <= l;
    modADrv <= a;
    modBDrv <= b;
    repeat (8) @(posedge clk);
  endtask

  function automatic logic [11:0] reg_addr(input int i);
    logic [11:0] fixed [4] = '{12'h140, 12'h148, 12'h160, 12'h168};
    return i < 4 ? fixed[i] : 12'h180 + 12'(4 * (i - 4));
  endfunction

  // ====
  // scenarios
  task automatic t_regs;
    logic [15:0] msk [4] = '{16'he603, 16'h8877, 16'hf7f7, 16'hf7f7};
    for (int i = 0; i < 12; i++) begin
      rd(reg_addr(i), 16'h0, 1'b0);
      wr(reg_addr(i), 16'hffff);
      rd(reg_addr(i), i < 4 ? msk[i] : 16'h8f77, 1'b0);
    end
    rd(12'h144, 16'h0, 1'b1);
    rd(12'h141, 16'h0, 1'b1);
    check("thresh", thresholdSel, 1'b1);
    check("term", terminationSel, 1'b1);
    check("oe", lvdsOe, 8'hff);
    // reserved types select a constant zero, which the set invert bit turns high
    check("reserved lvds", lvdsOut, 8'hff);
    check("reserved ttl", ttlOut, 1'b1);
    for (int i = 0; i < 12; i++) wr(reg_addr(i), 16'h0);
    check("thresh low", thresholdSel, 1'b0);
    check("term low", terminationSel, 1'b0);
    $display("test regs done");
  endtask

  task automatic t_level;
    wr(12'h140, 16'h8200);
    wr(12'h148, 16'h8805); // inverted from ttl, index ignored
    wr(12'h180, 16'h8103);
    wr(12'h184, 16'h8922);
    wr(12'h188, 16'h8136);
    wr(12'h190, 16'h8200); // line 4 named as source, so set as input
    wr(12'h18c, 16'h8114);
    pins(1'b1, 8'h10, 8'h04, 8'h00);
    check("ttl inv", ttlOut, 1'b0);
    check("fanout", lvdsOut, 8'h09);
    check("dir", lvdsOe, 8'h0f);
    pins(1'b0, 8'h00, 8'h00, 8'h40);
    check("ttl inv", ttlOut, 1'b1);
    check("types", lvdsOut, 8'h06);
    @(posedge clk);
    ttlDrv <= 1'b1;
    repeat (3) @(posedge clk);
    @(negedge clk);
    check("early", ttlOut, 1'b1);
    @(negedge clk);
    check("on time", ttlOut, 1'b0);
    wr(12'h148, 16'h0805);
    pins(1'b0, 8'h00, 8'h00, 8'h40);
    check("disabled", ttlOut, 1'b0);
    $display("test level done");
  endtask

  task automatic t_edge;
    wr(12'h160, 16'hb1a0);
    wr(12'h140, 16'h8000);
    wr(12'h148, 16'h8000);
    pins(1'b1, 8'h00, 8'h00, 8'h00);
    check("no strobe", ttlOut, 1'b0);
    pins(1'b1, 8'h00, 8'h01, 8'h00);
    check("rise latch", ttlOut, 1'b1);
    pins(1'b0, 8'h00, 8'h00, 8'h00);
    check("fall skip", ttlOut, 1'b1);
    wr(12'h140, 16'h8401);
    pins(1'b0, 8'h00, 8'h00, 8'h02);
    check("rise skip", ttlOut, 1'b1);
    pins(1'b0, 8'h00, 8'h00, 8'h00);
    check("fall latch", ttlOut, 1'b0);
    wr(12'h168, 16'h9600);
    wr(12'h19c, 16'h8003);
    wr(12'h148, 16'h8017);
    pins(1'b0, 8'h80, 8'h00, 8'h00);
    check("line idle", ttlOut, 1'b0);
    pins(1'b0, 8'hc0, 8'h00, 8'h00);
    check("line latch", ttlOut, 1'b1);
    $display("test edge done");
  endtask

  // ====
  // verdict and run control
  task automatic close_out;
    $display("comparisons %0d mismatches %0d", comparisons, mismatches);
    if (mismatches == 0 && comparisons > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  initial begin
    repeat (6) @(posedge clk);
    rst_b <= 1'b1;
    t_regs;
    t_level;
    t_edge;
    close_out;
  end

  // whole run is about three hundred cycles; the 5000-cycle limit, over fifteen times that, means a hang
  initial begin
    repeat (5000) @(posedge clk);
    mismatches++;
    close_out;
  end
endmodule
`default_nettype wire
